//--- hdl/adcdc_byte_reg.v
// Purpose: One byte-wide control register with write mask and soft clear
// Assumes: Single clock, asynchronous active-high reset
// Notes: Only bits set in the mask can be written; others are written as zero
`timescale 1ns/1ps

module adcdc_byte_reg #(
	parameter [7:0] MASK = 8'hff,
	parameter [7:0] RST_VAL = 8'h00
) (
	// Clock and reset
	input wire clock_i,
	input wire reset_i,
	// Control
	input wire clear_i,
	input wire write_i,
	input wire [7:0] data_i,
	// State
	output reg [7:0] value_o
);

	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			value_o <= RST_VAL;
		end else if (clear_i) begin
			value_o <= RST_VAL;
		end else if (write_i) begin
			value_o <= data_i & MASK;
		end
	end

endmodule // adcdc_byte_reg

//--- hdl/adcdc_ctrl_regs.v
// Purpose: Digital back-end control register bank for a dual-channel converter
// Assumes: Avalon-MM slave with waitrequest, 25 MHz clock_i
// Notes: Reserved bits read zero; unmapped reads return zero
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "adcdc_regs.vh"

module adcdc_ctrl_regs #(
	parameter [3:0] SRST_CYCLES = `ADCDC_SRST_CYCLES
) (
	// Clock and reset
	input wire clock_i,
	input wire reset_i,
	// Avalon-MM slave
	input wire [5:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	// Normal and fast overrange sources from the converter core
	input wire [1:0] ovr_normal_i,
	input wire [1:0] ovr_fast_i,
	// Controls to the data path
	output reg [1:0] noise_shaping_off_a_o,
	output reg [1:0] noise_shaping_off_b_o,
	output reg dither_active_a_o,
	output reg dither_active_b_o,
	output reg gain_stage_on_a_o,
	output reg gain_stage_on_b_o,
	output reg test_pattern_en_o,
	output reg [2:0] distortion_tune_a_o,
	output reg [2:0] distortion_tune_b_o,
	output reg fast_overrange_select_o,
	output reg [1:0] overrange_pins_o,
	output reg pattern_align_o,
	output reg offset_binary_o,
	output reg soft_reset_busy_o
);

	wire [3:0] reg_idx;
	wire addr_ok;
	wire lane0_on;
	wire bus_write;
	wire [7:0] wdata;
	wire soft_clear;
	wire wr_dither;
	wire wr_gain_a;
	wire wr_gain_b;
	wire wr_patrst;
	wire wr_tune_a;
	wire wr_tune_b;
	wire wr_format;
	wire [7:0] dither_q;
	wire [7:0] gain_a_q;
	wire [7:0] gain_b_q;
	wire [7:0] patrst_q;
	wire [7:0] tune_a_q;
	wire [7:0] tune_b_q;
	wire [7:0] format_q;
	reg [3:0] srst_count;
	reg [7:0] next_rdata;
	reg ack;
	reg [1:0] ovr_meta;
	reg [1:0] ovr_sync;
	reg [1:0] fovr_meta;
	reg [1:0] fovr_sync;

	assign reg_idx = avs_address_i[3:0];
	assign addr_ok = (avs_address_i[5:4] == 2'h0);
	assign lane0_on = avs_byteenable_i[0];
	assign bus_write = avs_write_i & ~ack & addr_ok & lane0_on & ~soft_reset_busy_o;
	assign wdata = avs_writedata_i[7:0];
	assign soft_clear = soft_reset_busy_o;

	// Per-register write strobes
	assign wr_dither = bus_write & (reg_idx == `ADCDC_IDX_DITHER);
	assign wr_gain_a = bus_write & (reg_idx == `ADCDC_IDX_GAIN_A);
	assign wr_gain_b = bus_write & (reg_idx == `ADCDC_IDX_GAIN_B);
	assign wr_patrst = bus_write & (reg_idx == `ADCDC_IDX_PATRST);
	assign wr_tune_a = bus_write & (reg_idx == `ADCDC_IDX_TUNE_A);
	assign wr_tune_b = bus_write & (reg_idx == `ADCDC_IDX_TUNE_B);
	assign wr_format = bus_write & (reg_idx == `ADCDC_IDX_FORMAT);

	// Register bank, reserved bits masked to zero
	adcdc_byte_reg #(.MASK(`ADCDC_MASK_DITHER), .RST_VAL(`ADCDC_RST_VAL)) u_dither (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.clear_i(soft_clear),
		.write_i(wr_dither),
		.data_i(wdata),
		.value_o(dither_q)
	);

	adcdc_byte_reg #(.MASK(`ADCDC_MASK_GAIN), .RST_VAL(`ADCDC_RST_VAL)) u_gain_a (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.clear_i(soft_clear),
		.write_i(wr_gain_a),
		.data_i(wdata),
		.value_o(gain_a_q)
	);

	adcdc_byte_reg #(.MASK(`ADCDC_MASK_GAIN), .RST_VAL(`ADCDC_RST_VAL)) u_gain_b (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.clear_i(soft_clear),
		.write_i(wr_gain_b),
		.data_i(wdata),
		.value_o(gain_b_q)
	);

	adcdc_byte_reg #(.MASK(`ADCDC_MASK_PATRST), .RST_VAL(`ADCDC_RST_VAL)) u_patrst (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.clear_i(soft_clear),
		.write_i(wr_patrst),
		.data_i(wdata),
		.value_o(patrst_q)
	);

	adcdc_byte_reg #(.MASK(`ADCDC_MASK_TUNE_A), .RST_VAL(`ADCDC_RST_VAL)) u_tune_a (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.clear_i(soft_clear),
		.write_i(wr_tune_a),
		.data_i(wdata),
		.value_o(tune_a_q)
	);

	adcdc_byte_reg #(.MASK(`ADCDC_MASK_TUNE_B), .RST_VAL(`ADCDC_RST_VAL)) u_tune_b (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.clear_i(soft_clear),
		.write_i(wr_tune_b),
		.data_i(wdata),
		.value_o(tune_b_q)
	);

	adcdc_byte_reg #(.MASK(`ADCDC_MASK_FORMAT), .RST_VAL(`ADCDC_RST_VAL)) u_format (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.clear_i(soft_clear),
		.write_i(wr_format),
		.data_i(wdata),
		.value_o(format_q)
	);

	// Soft reset sequencer
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			srst_count <= 4'h0;
			soft_reset_busy_o <= 1'b0;
		end else if (soft_reset_busy_o) begin
			if (srst_count == 4'h1) begin
				soft_reset_busy_o <= 1'b0;
			end
			srst_count <= srst_count - 4'h1;
		end else if (patrst_q[`ADCDC_SRST_BIT]) begin
			soft_reset_busy_o <= 1'b1;
			srst_count <= SRST_CYCLES;
		end
	end

	// Read mux
	always @* begin
		next_rdata = 8'h00;
		case (reg_idx)
			`ADCDC_IDX_DITHER: next_rdata = dither_q;
			`ADCDC_IDX_GAIN_A: next_rdata = gain_a_q;
			`ADCDC_IDX_GAIN_B: next_rdata = gain_b_q;
			`ADCDC_IDX_PATRST: next_rdata = patrst_q;
			`ADCDC_IDX_TUNE_A: next_rdata = tune_a_q;
			`ADCDC_IDX_TUNE_B: next_rdata = tune_b_q;
			`ADCDC_IDX_FORMAT: next_rdata = format_q;
			default: next_rdata = 8'h00;
		endcase
		if (!addr_ok) begin
			next_rdata = 8'h00;
		end
	end

	// Bus handshake, one wait state per access outside soft reset
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ack <= 1'b0;
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
		end else if (ack) begin
			ack <= 1'b0;
			avs_waitrequest_o <= 1'b1;
		end else if ((avs_read_i | avs_write_i) & ~soft_reset_busy_o) begin
			ack <= 1'b1;
			avs_waitrequest_o <= 1'b0;
			if (avs_read_i) begin
				avs_readdata_o <= {24'h000000, next_rdata};
			end
		end
	end

	// Normal overrange from pins
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ovr_meta <= 2'h0;
			ovr_sync <= 2'h0;
		end else begin
			ovr_meta <= ovr_normal_i;
			ovr_sync <= ovr_meta;
		end
	end

	// Fast overrange from pins
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			fovr_meta <= 2'h0;
			fovr_sync <= 2'h0;
		end else begin
			fovr_meta <= ovr_fast_i;
			fovr_sync <= fovr_meta;
		end
	end

	// Dither field copies
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			noise_shaping_off_a_o <= 2'h0;
			noise_shaping_off_b_o <= 2'h0;
		end else begin
			noise_shaping_off_a_o <= dither_q[`ADCDC_DITH_A_HI:`ADCDC_DITH_A_LO];
			noise_shaping_off_b_o <= dither_q[`ADCDC_DITH_B_HI:`ADCDC_DITH_B_LO];
		end
	end

	// Dither state, channel A
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			dither_active_a_o <= 1'b1;
		end else begin
			dither_active_a_o <= (dither_q[`ADCDC_DITH_A_HI:`ADCDC_DITH_A_LO]
				!= `ADCDC_DITH_OFF);
		end
	end

	// Dither state, channel B
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			dither_active_b_o <= 1'b1;
		end else begin
			dither_active_b_o <= (dither_q[`ADCDC_DITH_B_HI:`ADCDC_DITH_B_LO]
				!= `ADCDC_DITH_OFF);
		end
	end

	// Gain stage, channel A
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			gain_stage_on_a_o <= 1'b0;
		end else begin
			gain_stage_on_a_o <= gain_a_q[`ADCDC_GAIN_BIT];
		end
	end

	// Gain stage, channel B
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			gain_stage_on_b_o <= 1'b0;
		end else begin
			gain_stage_on_b_o <= gain_b_q[`ADCDC_GAIN_BIT];
		end
	end

	// Test pattern enable
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			test_pattern_en_o <= 1'b0;
		end else begin
			test_pattern_en_o <= patrst_q[`ADCDC_PAT_EN_BIT];
		end
	end

	// Distortion tuning, channel A
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			distortion_tune_a_o <= 3'h0;
		end else begin
			distortion_tune_a_o <= tune_a_q[`ADCDC_TUNE_HI:`ADCDC_TUNE_LO];
		end
	end

	// Distortion tuning, channel B
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			distortion_tune_b_o <= 3'h0;
		end else begin
			distortion_tune_b_o <= tune_b_q[`ADCDC_TUNE_HI:`ADCDC_TUNE_LO];
		end
	end

	// Overrange mode select
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			fast_overrange_select_o <= 1'b0;
		end else begin
			fast_overrange_select_o <= tune_a_q[`ADCDC_FOVR_BIT];
		end
	end

	// Overrange pin source
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			overrange_pins_o <= 2'h0;
		end else begin
			overrange_pins_o <= tune_a_q[`ADCDC_FOVR_BIT] ? fovr_sync : ovr_sync;
		end
	end

	// Pattern alignment
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			pattern_align_o <= 1'b0;
		end else begin
			pattern_align_o <= format_q[`ADCDC_ALIGN_BIT];
		end
	end

	// Output sample coding
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			offset_binary_o <= 1'b0;
		end else begin
			offset_binary_o <= format_q[`ADCDC_FMT_BIT];
		end
	end

endmodule // adcdc_ctrl_regs

//--- include/adcdc_regs.vh
// Purpose: Offsets, field positions, reset values and timing for the control bank
// Assumes: Byte registers, one per aligned 32-bit Avalon word
// Notes: Byte address is four times the register index
`ifndef ADCDC_REGS_VH
`define ADCDC_REGS_VH

// Register indices
`define ADCDC_IDX_DITHER 4'h1
`define ADCDC_IDX_GAIN_A 4'h3
`define ADCDC_IDX_GAIN_B 4'h4
`define ADCDC_IDX_PATRST 4'h6
`define ADCDC_IDX_TUNE_A 4'h7
`define ADCDC_IDX_TUNE_B 4'h8
`define ADCDC_IDX_FORMAT 4'h9

// Writable masks per register
`define ADCDC_MASK_DITHER 8'h3c
`define ADCDC_MASK_GAIN 8'h02
`define ADCDC_MASK_PATRST 8'h03
`define ADCDC_MASK_TUNE_A 8'h1e
`define ADCDC_MASK_TUNE_B 8'h1c
`define ADCDC_MASK_FORMAT 8'h03

// Field positions
`define ADCDC_DITH_A_HI 5
`define ADCDC_DITH_A_LO 4
`define ADCDC_DITH_B_HI 3
`define ADCDC_DITH_B_LO 2
`define ADCDC_GAIN_BIT 1
`define ADCDC_PAT_EN_BIT 1
`define ADCDC_SRST_BIT 0
`define ADCDC_TUNE_HI 4
`define ADCDC_TUNE_LO 2
`define ADCDC_FOVR_BIT 1
`define ADCDC_ALIGN_BIT 1
`define ADCDC_FMT_BIT 0

// Field values
`define ADCDC_DITH_OFF 2'h3
`define ADCDC_TUNE_LOWF 3'h2
`define ADCDC_TUNE_HIGHF 3'h7

// Reset value of every register
`define ADCDC_RST_VAL 8'h00

// Software reset length in cycles
`define ADCDC_SRST_CYCLES 4'h4

`endif

//--- verification/adc_digital_control_regs_bench.sv
// Purpose: Self-checking bench for the bank
// Assumes: Default soft reset length
// Notes: Read data checked from a queue
`timescale 1ns/1ps
module adc_digital_control_regs_bench;
	reg clock_i = 0, reset_i = 1, avs_read_i = 0, avs_write_i = 0;
	reg [5:0] avs_address_i = 0;
	reg [31:0] avs_writedata_i = 0;
	reg [3:0] avs_byteenable_i = 0;
	reg [1:0] ovr_normal_i = 0, ovr_fast_i = 0;
	wire [31:0] avs_readdata_o;
	wire [1:0] noise_shaping_off_a_o, noise_shaping_off_b_o, overrange_pins_o;
	wire [2:0] distortion_tune_a_o, distortion_tune_b_o;
	wire avs_waitrequest_o, dither_active_a_o, dither_active_b_o, gain_stage_on_a_o;
	wire gain_stage_on_b_o, test_pattern_en_o, fast_overrange_select_o, pattern_align_o;
	wire offset_binary_o, soft_reset_busy_o;
	int error_cnt = 0, checks_done = 0, n, i;
	reg [7:0] sh [0:63];
	reg [7:0] mk [0:63];
	reg [7:0] q [$];
	reg [7:0] v;
	adcdc_ctrl_regs adcdc_ctrl_regs_i (.clock_i, .reset_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
		.avs_waitrequest_o, .ovr_normal_i, .ovr_fast_i, .noise_shaping_off_a_o,
		.noise_shaping_off_b_o, .dither_active_a_o, .dither_active_b_o, .gain_stage_on_a_o,
		.gain_stage_on_b_o, .test_pattern_en_o, .distortion_tune_a_o, .distortion_tune_b_o,
		.fast_overrange_select_o, .overrange_pins_o, .pattern_align_o, .offset_binary_o,
		.soft_reset_busy_o);
	always #20 clock_i = ~clock_i;
	task automatic chk(input [31:0] s, input [31:0] e);
		checks_done++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, e);
		end
	endtask
	task complete_run;
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Bus cycle, held until waitrequest low
	task bus(input w, input [5:0] a, input [7:0] d, input [3:0] be);
		int k;
		@(posedge clock_i);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= {24'h0, d};
		avs_byteenable_i <= be;
		k = 0;
		do begin
			@(posedge clock_i);
			k++;
		end while (avs_waitrequest_o !== 1'b0 && k < 40);
		avs_write_i <= 0;
		avs_read_i <= 0;
		if (k >= 40) begin
			error_cnt++;
			complete_run;
		end
	endtask
	task wr(input [5:0] a, input [7:0] d);
		bus(1, a, d, 4'hf);
		sh[a] = d & mk[a];
	endtask
	task rd(input [5:0] a, input [7:0] e);
		q.push_back(e);
		bus(0, a, 8'h0, 4'hf);
	endtask
	task outs;
		@(posedge clock_i);
		chk({noise_shaping_off_a_o, noise_shaping_off_b_o}, sh[1][5:2]);
		chk(dither_active_a_o, sh[1][5:4] != 2'h3);
		chk(dither_active_b_o, sh[1][3:2] != 2'h3);
		chk(gain_stage_on_a_o, sh[3][1]);
		chk(gain_stage_on_b_o, sh[4][1]);
		chk(test_pattern_en_o, sh[6][1]);
		chk({distortion_tune_a_o, fast_overrange_select_o}, sh[7][4:1]);
		chk(distortion_tune_b_o, sh[8][4:2]);
		chk({pattern_align_o, offset_binary_o}, sh[9][1:0]);
		chk(soft_reset_busy_o, 1'b0);
	endtask
	// Read answers against the oldest note
	always @(posedge clock_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0)
			chk(avs_readdata_o, {24'h0, q.pop_front()});
	end
	initial begin
		n = $urandom(13870);
		for (i = 0; i < 64; i++) begin
			sh[i] = 8'h00;
			mk[i] = 8'h00;
		end
		mk[1] = 8'h3c;
		mk[3] = 8'h02;
		mk[4] = 8'h02;
		mk[6] = 8'h02;
		mk[7] = 8'h1e;
		mk[8] = 8'h1c;
		mk[9] = 8'h03;
		repeat (16) @(posedge clock_i);
		reset_i <= 0;
		for (i = 0; i < 10; i++)
			rd(i, 8'h00);
		outs;
		for (i = 0; i < 16; i++) begin
			wr(1, {2'h0, i[3:0], 2'h0});
			outs;
		end
		// Random data within writable bits, unmapped places included
		repeat (40) begin
			n = $urandom % 10;
			v = $urandom & mk[n];
			if (n == 6)
				v[0] = 1'b0;
			wr(n, v);
			rd(n, sh[n]);
			outs;
		end
		wr(6'h2a, 8'hff);
		rd(6'h2a, 8'h00);
		bus(1, 3, sh[3] ^ 8'h02, 4'h0);
		rd(3, sh[3]);
		wr(7, 8'h08);
		outs;
		wr(7, 8'h1e);
		outs;
		wr(8, 8'h1c);
		outs;
		ovr_normal_i <= 2'h1;
		ovr_fast_i <= 2'h2;
		for (i = 0; i < 2; i++) begin
			wr(7, {6'h0, i[0], 1'h0});
			repeat (4) @(posedge clock_i);
			chk(overrange_pins_o, i ? 2'h2 : 2'h1);
		end
		// Soft reset with live settings
		wr(1, 8'h3c);
		wr(9, 8'h03);
		bus(1, 6, 8'h03, 4'h1);
		@(posedge clock_i);
		chk(soft_reset_busy_o, 1'b1);
		for (i = 0; i < 10; i++) begin
			sh[i] = 8'h00;
			rd(i, 8'h00);
		end
		outs;
		complete_run;
	end
endmodule // adc_digital_control_regs_bench

//--- verification/adcdc_chk_asserts.sv
// Purpose: Bus to control output relations
// Assumes: One clock, async reset
// Notes: Bound to the bank
`timescale 1ns/1ps
module adcdc_chk #(
	parameter [3:0] SRST_CYCLES = 4'h4
) (
	// Clock and bus
	input clock_i,
	input reset_i,
	input [5:0] avs_address_i,
	input avs_write_i,
	input [31:0] avs_writedata_i,
	input [3:0] avs_byteenable_i,
	input avs_waitrequest_o,
	// Controls
	input dither_active_a_o,
	input dither_active_b_o,
	input gain_stage_on_a_o,
	input gain_stage_on_b_o,
	input test_pattern_en_o,
	input [2:0] distortion_tune_a_o,
	input fast_overrange_select_o,
	input offset_binary_o,
	input soft_reset_busy_o
);
	wire wd = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
	wire [7:0] d = avs_writedata_i[7:0];
	reg [3:0] bc;
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i)
			bc <= 4'h0;
		else
			bc <= soft_reset_busy_o ? bc + 4'h1 : 4'h0;
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	sequence srst_go;
		soft_reset_busy_o ##1 soft_reset_busy_o;
	endsequence
	AST_DITH_A: assert property (wd && avs_address_i == 6'h1 |=>
		dither_active_a_o == ($past(d[5:4]) != 2'h3)) else $error("dither a");
	AST_DITH_B: assert property (wd && avs_address_i == 6'h1 |=>
		dither_active_b_o == ($past(d[3:2]) != 2'h3)) else $error("dither b");
	AST_GAIN_A: assert property (wd && avs_address_i == 6'h3 |=>
		gain_stage_on_a_o == $past(d[1])) else $error("gain a");
	AST_GAIN_B: assert property (wd && avs_address_i == 6'h4 |=>
		gain_stage_on_b_o == $past(d[1])) else $error("gain b");
	AST_PAT: assert property (wd && avs_address_i == 6'h6 && !d[0] |=>
		test_pattern_en_o == $past(d[1])) else $error("pattern");
	AST_TUNE: assert property (wd && avs_address_i == 6'h7 |=>
		{distortion_tune_a_o, fast_overrange_select_o} == $past(d[4:1])) else $error("tune");
	AST_FMT: assert property (wd && avs_address_i == 6'h9 |=>
		offset_binary_o == $past(d[0])) else $error("format");
	AST_SRST_GO: assert property (wd && avs_address_i == 6'h6 && d[0] |=>
		srst_go) else $error("soft reset start");
	AST_SRST_LEN: assert property ($fell(soft_reset_busy_o) |->
		bc == SRST_CYCLES) else $error("soft reset length");
	AST_SRST_ZERO: assert property ($fell(soft_reset_busy_o) |-> !gain_stage_on_a_o &&
		!test_pattern_en_o && dither_active_a_o && !offset_binary_o) else $error("defaults");
endmodule // adcdc_chk
bind adcdc_ctrl_regs adcdc_chk #(.SRST_CYCLES(SRST_CYCLES)) adcdc_chk_i (.clock_i, .reset_i,
	.avs_address_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o,
	.dither_active_a_o, .dither_active_b_o, .gain_stage_on_a_o, .gain_stage_on_b_o,
	.test_pattern_en_o, .distortion_tune_a_o, .fast_overrange_select_o, .offset_binary_o,
	.soft_reset_busy_o);
